// ### logic/tei_top.sv
`timescale 1ns/1ps
// Summary of operation
// - With gate select set, timer A runs only while interrupt pin A is high.
// - Edge select A set: a falling edge on pin A sets flag A.
// - Edge select A clear: a low level on pin A sets flag A.
// - With gate select set, timer B runs only while interrupt pin B is high.
// - Edge select B set: a falling edge on pin B sets flag B.
// - Edge select B clear: a low level on pin B sets flag B.
// - Timer A in counter mode counts each falling edge of count pin A.
// - Timer B in counter mode counts each falling edge of count pin B.
module tei_top
  import tei_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_WIDTH
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ext_irq_a_n,
  input  wire logic        ext_irq_b_n,
  input  wire logic        count_pin_a,
  input  wire logic        count_pin_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq
);

  initial begin
    if (WIDTH != TIMER_WIDTH) begin
      $error("tei_top supports only the documented timer width");
    end
  end

  logic [3:0]          pins_s;
  logic [3:0]          pins_d1_q;
  logic [CTL_WIDTH-1:0] timer_ctl_reg_q;
  logic [ST_WIDTH-1:0] status_q;
  logic [ST_WIDTH-1:0] mask_q;
  logic [WIDTH-1:0]    count_a;
  logic [WIDTH-1:0]    count_b;
  logic                ovf_a;
  logic                ovf_b;
  logic                irq_a_s;
  logic                irq_b_s;
  logic                fall_irq_a;
  logic                fall_irq_b;
  logic                fall_cnt_a;
  logic                fall_cnt_b;
  logic                run_a;
  logic                run_b;
  logic                set_irq_a;
  logic                set_irq_b;
  logic [ST_WIDTH-1:0] status_set;
  logic [ST_WIDTH-1:0] status_clr;
  logic                wr_ctl;
  logic                ld_a;
  logic                ld_b;

  function automatic logic fell(input logic prev, input logic now);
    return prev && !now;
  endfunction

  tei_sync #(
    .WIDTH    (4)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({count_pin_b, count_pin_a, ext_irq_b_n, ext_irq_a_n}),
    .sync_out (pins_s)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_d1_q <= 4'hf;
    end else begin
      pins_d1_q <= pins_s;
    end
  end

  always_comb begin
    irq_a_s    = pins_s[0];
    irq_b_s    = pins_s[1];
    fall_irq_a = fell(pins_d1_q[0], pins_s[0]);
    fall_irq_b = fell(pins_d1_q[1], pins_s[1]);
    fall_cnt_a = fell(pins_d1_q[2], pins_s[2]);
    fall_cnt_b = fell(pins_d1_q[3], pins_s[3]);
  end

  // gate: pin low holds the timer when its gate select is set
  always_comb begin
    run_a = timer_ctl_reg_q[CTL_RUN_A] &&
            (!timer_ctl_reg_q[CTL_GATE_SEL_A] || irq_a_s);
    run_b = timer_ctl_reg_q[CTL_RUN_B] &&
            (!timer_ctl_reg_q[CTL_GATE_SEL_B] || irq_b_s);
  end

  always_comb begin
    set_irq_a = timer_ctl_reg_q[CTL_EDGE_SEL_A] ? fall_irq_a
                                                  : !irq_a_s;
    set_irq_b = timer_ctl_reg_q[CTL_EDGE_SEL_B] ? fall_irq_b
                                                  : !irq_b_s;
  end

  always_comb begin
    wr_ctl = reg_wr && (reg_addr == ADDR_CTL);
    ld_a   = reg_wr && (reg_addr == ADDR_TIMER_A);
    ld_b   = reg_wr && (reg_addr == ADDR_TIMER_B);
  end

  tei_timer #(
    .WIDTH        (WIDTH)
  ) u_timer_a (
    .clk          (clk),
    .rst_b        (rst_b),
    .run_en       (run_a),
    .counter_mode (timer_ctl_reg_q[CTL_COUNTER_A]),
    .pin_fall     (fall_cnt_a),
    .load         (ld_a),
    .load_val     (reg_wdata[WIDTH-1:0]),
    .count_q      (count_a),
    .ovf          (ovf_a)
  );

  tei_timer #(
    .WIDTH        (WIDTH)
  ) u_timer_b (
    .clk          (clk),
    .rst_b        (rst_b),
    .run_en       (run_b),
    .counter_mode (timer_ctl_reg_q[CTL_COUNTER_B]),
    .pin_fall     (fall_cnt_b),
    .load         (ld_b),
    .load_val     (reg_wdata[WIDTH-1:0]),
    .count_q      (count_b),
    .ovf          (ovf_b)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_ctl_reg_q <= CTL_RESET;
    end else if (wr_ctl) begin
      timer_ctl_reg_q <= reg_wdata[CTL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= MASK_RESET;
    end else if (reg_wr && (reg_addr == ADDR_MASK)) begin
      mask_q <= reg_wdata[ST_WIDTH-1:0];
    end
  end

  always_comb begin
    status_set           = '0;
    status_set[ST_IRQ_A] = set_irq_a;
    status_set[ST_IRQ_B] = set_irq_b;
    status_set[ST_OVF_A] = ovf_a;
    status_set[ST_OVF_B] = ovf_b;
    status_clr           = '0;
    if (reg_wr && (reg_addr == ADDR_STATUS)) begin
      status_clr = reg_wdata[ST_WIDTH-1:0];
    end
  end

  // sticky flags, write one to clear, a set in the same cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_q & ~status_clr) | status_set) & mask_q);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_CTL:     reg_rdata <= 32'(timer_ctl_reg_q);
          ADDR_STATUS:  reg_rdata <= 32'(status_q);
          ADDR_MASK:    reg_rdata <= 32'(mask_q);
          ADDR_TIMER_A: reg_rdata <= 32'(count_a);
          ADDR_TIMER_B: reg_rdata <= 32'(count_b);
          ADDR_PINS:    reg_rdata <= 32'(pins_s);
          default:      reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ### logic/tei_pkg.sv
package tei_pkg;

  localparam int unsigned TIMER_WIDTH = 16;
  localparam int unsigned SYNC_STAGES = 2;

  // register map, word index is byte address / 4
  localparam logic [3:0] ADDR_CTL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_MASK     = 4'h2;
  localparam logic [3:0] ADDR_TIMER_A  = 4'h3;
  localparam logic [3:0] ADDR_TIMER_B  = 4'h4;
  localparam logic [3:0] ADDR_PINS     = 4'h5;

  // control register field positions
  localparam int unsigned CTL_RUN_A       = 0;
  localparam int unsigned CTL_RUN_B       = 1;
  localparam int unsigned CTL_GATE_SEL_A  = 2;
  localparam int unsigned CTL_GATE_SEL_B  = 3;
  localparam int unsigned CTL_EDGE_SEL_A  = 4;
  localparam int unsigned CTL_EDGE_SEL_B  = 5;
  localparam int unsigned CTL_COUNTER_A   = 6;
  localparam int unsigned CTL_COUNTER_B   = 7;
  localparam int unsigned CTL_WIDTH       = 8;

  // status / mask field positions
  localparam int unsigned ST_IRQ_A   = 0;
  localparam int unsigned ST_IRQ_B   = 1;
  localparam int unsigned ST_OVF_A   = 2;
  localparam int unsigned ST_OVF_B   = 3;
  localparam int unsigned ST_WIDTH   = 4;

  localparam logic [7:0]  CTL_RESET    = 8'h00;
  localparam logic [3:0]  STATUS_RESET = 4'h0;
  localparam logic [3:0]  MASK_RESET   = 4'h0;
  localparam logic [15:0] TIMER_RESET  = 16'h0000;

endpackage

// ### logic/tei_sync.sv
`timescale 1ns/1ps
module tei_sync
  import tei_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("tei_sync width must be at least one");
    end
  end

  logic [WIDTH-1:0] meta_q;

  // pins idle high; reset to high so no false falling edge at release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### logic/tei_timer.sv
`timescale 1ns/1ps
module tei_timer
  import tei_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             run_en,
  input  wire logic             counter_mode,
  input  wire logic             pin_fall,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count_q,
  output logic                  ovf
);

  initial begin
    if (WIDTH < 2 || WIDTH > 32) begin
      $error("tei_timer width out of range");
    end
  end

  logic step;

  // counter mode steps on pin falling edges, timer mode every clock
  always_comb begin
    step = run_en && (counter_mode ? pin_fall : 1'b1);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= WIDTH'(TIMER_RESET);
      ovf     <= 1'b0;
    end else begin
      ovf <= 1'b0;
      if (load) begin
        count_q <= load_val;
      end else if (step) begin
        count_q <= count_q + WIDTH'(1);
        ovf     <= &count_q;
      end
    end
  end

endmodule

// ### verif/tei_board.sv
`timescale 1ns/1ps
module tei_board (
  input  wire logic       clk,
  output logic      [3:0] pin
);
  // pull-ups keep every pin idle high
  initial pin = 4'hf;
  // each level is held 4 cycles, above the 1 cycle minimum
  task automatic drive(input int i, input logic v);
    @(posedge clk);
    pin[i] <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### verif/tei_top_chk.sv
`timescale 1ns/1ps
module tei_top_chk
  import tei_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ext_irq_a_n,
  input wire logic        ext_irq_b_n,
  input wire logic        count_pin_a,
  input wire logic        count_pin_b,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq
);
  logic [7:0] ctl_q;
  logic [3:0] mask_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of control and mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q  <= CTL_RESET;
      mask_q <= MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CTL) ctl_q <= reg_wdata[7:0];
      if (reg_addr == ADDR_MASK) mask_q <= reg_wdata[3:0];
    end
  end
  sequence low_a;
    !ext_irq_a_n [*4];
  endsequence
  sequence low_b;
    !ext_irq_b_n [*4];
  endsequence
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero");
  chk_unmapped_rd: assert property (reg_rd && reg_addr > ADDR_PINS |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctl_readback: assert property (reg_rd && reg_addr == ADDR_CTL |=> reg_rdata == {24'h0, ctl_q})
    else $error("control readback wrong");
  chk_edge_a_irq: assert property ($fell(ext_irq_a_n) && ctl_q[4] && mask_q[0] |-> ##[1:6] irq)
    else $error("edge a no irq");
  chk_edge_b_irq: assert property ($fell(ext_irq_b_n) && ctl_q[5] && mask_q[1] |-> ##[1:6] irq)
    else $error("edge b no irq");
  chk_level_a_irq: assert property (low_a ##0 (!ctl_q[4] && mask_q[0]) |-> ##[0:2] irq)
    else $error("level a no irq");
  chk_level_b_irq: assert property (low_b ##0 (!ctl_q[5] && mask_q[1]) |-> ##[0:2] irq)
    else $error("level b no irq");
  chk_masked_quiet: assert property ((mask_q == 4'h0) [*3] |-> !irq)
    else $error("irq while masked");
endmodule

// ### verif/tb_tei_top.sv
`timescale 1ns/1ps
module tb_tei_top;
  import tei_pkg::*;
  logic        clk, rst_b, reg_wr, reg_rd, irq;
  logic [3:0]  reg_addr, pin;
  logic [31:0] reg_wdata, reg_rdata, q, a;
  int          error_cnt, num_checks;
  tei_board u_tei_board(.clk(clk), .pin(pin));
  tei_top u_tei_top(.clk(clk), .rst_b(rst_b), .ext_irq_a_n(pin[0]), .ext_irq_b_n(pin[1]),
    .count_pin_a(pin[2]), .count_pin_b(pin[3]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic irqchk(input logic e);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, e}, {31'h0, irq});
  endtask
  task automatic t_edge;
    wr(ADDR_CTL, 32'h30);
    wr(4'h9, 32'hffffffff);
    rd(4'h9);
    chk(32'h0, q);
    for (int i = 0; i < 2; i++) begin
      u_tei_board.drive(i, 1'b0);
      rd(ADDR_STATUS);
      chk(32'h1 << i, q);
      irqchk(1'b0);
      wr(ADDR_STATUS, 32'h1 << i);
      rd(ADDR_STATUS);
      chk(32'h0, q);
      u_tei_board.drive(i, 1'b1);
    end
    // unmasked edge raises irq once; a clear while the pin stays low sticks
    wr(ADDR_MASK, 32'h3);
    for (int i = 0; i < 2; i++) begin
      u_tei_board.drive(i, 1'b0);
      irqchk(1'b1);
      wr(ADDR_STATUS, 32'h1 << i);
      irqchk(1'b0);
      u_tei_board.drive(i, 1'b1);
    end
    $display("edge test done");
  endtask
  task automatic t_level;
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_MASK, 32'h3);
    for (int i = 0; i < 2; i++) begin
      u_tei_board.drive(i, 1'b0);
      irqchk(1'b1);
      wr(ADDR_STATUS, 32'h1 << i);
      rd(ADDR_STATUS);
      chk(32'h1 << i, q);
      u_tei_board.drive(i, 1'b1);
      wr(ADDR_STATUS, 32'h1 << i);
      irqchk(1'b0);
    end
    $display("level test done");
  endtask
  task automatic t_count;
    wr(ADDR_CTL, 32'hc3);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_TIMER_A + 4'(i), 32'h0);
      repeat (5) begin
        u_tei_board.drive(2 + i, 1'b0);
        u_tei_board.drive(2 + i, 1'b1);
      end
      rd(ADDR_TIMER_A + 4'(i));
      chk(32'h5, q);
    end
    $display("count test done");
  endtask
  task automatic t_gate;
    wr(ADDR_CTL, 32'h0f);
    for (int i = 0; i < 2; i++) begin
      u_tei_board.drive(i, 1'b0);
      rd(ADDR_TIMER_A + 4'(i));
      a = q;
      rd(ADDR_TIMER_A + 4'(i));
      chk(a, q);
      u_tei_board.drive(i, 1'b1);
      rd(ADDR_TIMER_A + 4'(i));
      chk(32'h1, {31'h0, q !== a});
    end
    $display("gate test done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_edge();
    t_level();
    t_count();
    t_gate();
    summarize();
  end
endmodule
bind tei_top tei_top_chk u_tei_top_chk(.clk(clk), .rst_b(rst_b), .ext_irq_a_n(ext_irq_a_n),
  .ext_irq_b_n(ext_irq_b_n), .count_pin_a(count_pin_a), .count_pin_b(count_pin_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq));
